// ---- rtl/bcr_bridge_config.sv ----
// Bridge configuration register with start-up sequencing and audio source select
`timescale 1ns/100ps
`default_nettype none
`include "bcr_consts.svh"
// Functional notes
// - External-control bit set disables internal bridge control and receiver initialization.
// - External-control bit is loaded from strap pin b at power-up.
// - Interrupt-enable bit routes receiver interrupts to active-low irq pin; resets zero.
// - With remote-load-disable clear, device fetches remote display id into local memory.
// - Remote-load-disable set skips that fetch; bit loaded from strap pin b.
// - Automatic receiver setup runs by default while auto-disable bit stays zero.
// - Writing one to auto-disable stops automatic receiver setup.
// - TDM bit, reset zero, makes device handle HDMI audio in TDM form.
// - Local audio comes from the device's own I2S input pins.
// - Auxiliary-audio bit enables an extra two-channel auxiliary stream.
// - Auxiliary-audio bit is loaded from strap pin a at power-up.
// - Status flag shows pending receiver interrupt regardless of interrupt enable.
module bcr_bridge_config #(
    parameter int AUD_W = 4
) (
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               reset_n_in,
    // Mode-select straps
    input  wire logic               strap_pin_a_in,
    input  wire logic               strap_pin_b_in,
    // Register access port
    input  wire logic [7:0]         reg_addr_in,
    input  wire logic               reg_wr_en_in,
    input  wire logic               reg_rd_en_in,
    input  wire logic [7:0]         reg_wdata_in,
    output logic      [7:0]         reg_rdata_out,
    // HDMI receiver side
    input  wire logic               hdmi_irq_in,
    input  wire logic               rx_init_done_in,
    input  wire logic               edid_load_done_in,
    output logic                    internal_ctl_en_out,
    output logic                    rx_init_req_out,
    output logic                    edid_load_req_out,
    output logic                    init_done_out,
    output logic                    irq_out_n,
    // Audio path
    input  wire logic [AUD_W-1:0]   hdmi_audio_in,
    input  wire logic [AUD_W-1:0]   i2s_audio_in,
    output logic      [AUD_W-1:0]   audio_out,
    output logic                    audio_src_local_out,
    output logic                    tdm_enable_out,
    output logic                    aux_audio_en_out
);
    import bcr_pkg::*;

    logic [7:0]  bridge_config;
    logic        strap_done;
    bcr_state_t  state;
    bcr_state_t  next_state;
    logic        cfg_wr;
    logic        external_control_select;
    logic        auto_dis;
    logic        edid_dis;

    assign cfg_wr   = reg_wr_en_in && (reg_addr_in == `BCR_ADDR_BRIDGE_CONFIG);
    assign external_control_select  = bridge_config[`BCR_BIT_EXTERNAL_CONTROL_SELECT];
    assign auto_dis = bridge_config[`BCR_BIT_AUTO_DIS];
    assign edid_dis = bridge_config[`BCR_BIT_EDID_DIS];

    // Strap capture happens once, on the first edge after reset release
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    // Configuration register: straps first, then software writes
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bridge_config <= `BCR_CFG_RESET;
        end else if (!strap_done) begin
            bridge_config                    <= `BCR_CFG_RESET;
            bridge_config[`BCR_BIT_EXTERNAL_CONTROL_SELECT]  <= strap_pin_b_in;
            bridge_config[`BCR_BIT_EDID_DIS] <= strap_pin_b_in;
            bridge_config[`BCR_BIT_AUX_EN]   <= strap_pin_a_in;
        end else if (cfg_wr) begin
            bridge_config <= reg_wdata_in & `BCR_CFG_WMASK;
        end
    end

    // Read data: status, configuration, zero elsewhere
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_en_in) begin
            unique case (reg_addr_in)
                `BCR_ADDR_BRIDGE_STATUS: begin
                    reg_rdata_out <= {1'b0, hdmi_irq_in, 6'h00};
                end
                `BCR_ADDR_BRIDGE_CONFIG: begin
                    reg_rdata_out <= bridge_config;
                end
                default: begin
                    reg_rdata_out <= 8'h00;
                end
            endcase
        end
    end

    // Start-up sequencer: remote display id load, then receiver setup
    always_comb begin
        next_state = state;
        unique case (state)
            S_STRAP: begin
                next_state = S_EDID;
            end
            S_EDID: begin
                if (edid_dis || edid_load_done_in) begin
                    next_state = S_INIT;
                end
            end
            S_INIT: begin
                if (external_control_select || auto_dis || rx_init_done_in) begin
                    next_state = S_DONE;
                end
            end
            S_DONE: begin
                next_state = S_DONE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= S_STRAP;
        end else if (strap_done) begin
            state <= next_state;
        end
    end

    // Requests to the receiver and loader
    assign edid_load_req_out   = (state == S_EDID) && !edid_dis;
    assign rx_init_req_out     = (state == S_INIT) && !external_control_select && !auto_dis;
    assign internal_ctl_en_out = !external_control_select;
    assign init_done_out       = (state == S_DONE);

    // Interrupt pin, active low, gated by the enable bit
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= !(hdmi_irq_in && bridge_config[`BCR_BIT_INT_EN]);
        end
    end

    // Downstream audio source mux
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            audio_out <= '0;
        end else if (bridge_config[`BCR_BIT_AUDIO_SRC]) begin
            audio_out <= i2s_audio_in;
        end else begin
            audio_out <= hdmi_audio_in;
        end
    end

    // Audio mode controls
    assign audio_src_local_out = bridge_config[`BCR_BIT_AUDIO_SRC];
    assign tdm_enable_out      = bridge_config[`BCR_BIT_TDM];
    assign aux_audio_en_out    = bridge_config[`BCR_BIT_AUX_EN];

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_cfg_read;
        reg_rd_en_in && reg_addr_in == `BCR_ADDR_BRIDGE_CONFIG;
    endsequence

    sequence s_auto_off_write;
        strap_done && cfg_wr && reg_wdata_in[`BCR_BIT_AUTO_DIS];
    endsequence

    a_ext_blocks_init: assert property (
        external_control_select |-> !rx_init_req_out && !internal_ctl_en_out)
        else $error("init requested under external control");
    a_strap_ext_load: assert property (
        !strap_done ##1 strap_done |-> external_control_select == $past(strap_pin_b_in))
        else $error("external control bit not loaded from strap b");
    a_strap_aux_load: assert property (
        !strap_done ##1 strap_done |-> aux_audio_en_out == $past(strap_pin_a_in)
            && edid_dis == $past(strap_pin_b_in))
        else $error("strap bits not loaded");
    a_irq_pin_gate: assert property (
        strap_done |=> irq_out_n == !($past(hdmi_irq_in) && $past(bridge_config[`BCR_BIT_INT_EN])))
        else $error("irq pin does not follow enabled interrupt");
    a_status_irq_flag: assert property (
        reg_rd_en_in && reg_addr_in == `BCR_ADDR_BRIDGE_STATUS
            |=> reg_rdata_out[`BCR_STS_BIT_HDMI_INT] == $past(hdmi_irq_in))
        else $error("status interrupt flag wrong");
    a_edid_load_req: assert property (
        state == S_EDID && !edid_dis |-> edid_load_req_out)
        else $error("remote load not requested");
    // Load request must really start right after the strap edge, not only mirror the state
    a_edid_load_start: assert property (
        $rose(strap_done) && !edid_dis && !cfg_wr |=> edid_load_req_out)
        else $error("remote load not started after strap load");
    a_edid_skip: assert property (
        state == S_EDID && edid_dis |-> !edid_load_req_out ##1 state == S_INIT)
        else $error("remote load not skipped");
    a_auto_off_write: assert property (
        s_auto_off_write |=> !rx_init_req_out [*2])
        else $error("auto setup continues after disable");
    a_rsvd_reads_zero: assert property (
        s_cfg_read |=> reg_rdata_out[`BCR_BIT_RSVD] == 1'b0)
        else $error("reserved bit reads nonzero");
    a_audio_src_mux: assert property (
        strap_done |=> audio_out == ($past(audio_src_local_out) ?
            $past(i2s_audio_in) : $past(hdmi_audio_in)))
        else $error("audio source mux wrong");
    a_tdm_follows_write: assert property (
        strap_done && cfg_wr |=> tdm_enable_out == $past(reg_wdata_in[`BCR_BIT_TDM]))
        else $error("tdm enable not written");
endmodule // bcr_bridge_config
`default_nettype wire

// ---- rtl/bcr_consts.svh ----
// Offsets, field positions and reset values of the bridge configuration block
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH
`define BCR_ADDR_BRIDGE_STATUS 8'h50
`define BCR_ADDR_BRIDGE_CONFIG 8'h54
`define BCR_BIT_EXTERNAL_CONTROL_SELECT        7
`define BCR_BIT_INT_EN         6
`define BCR_BIT_EDID_DIS       5
`define BCR_BIT_AUTO_DIS       4
`define BCR_BIT_RSVD           3
`define BCR_BIT_TDM            2
`define BCR_BIT_AUDIO_SRC      1
`define BCR_BIT_AUX_EN         0
`define BCR_STS_BIT_HDMI_INT   6
`define BCR_CFG_RESET          8'h00
`define BCR_CFG_WMASK          8'hF7
`endif

// ---- rtl/bcr_pkg.sv ----
// Types shared by the bridge configuration block
package bcr_pkg;
    typedef enum logic [1:0] {
        S_STRAP,
        S_EDID,
        S_INIT,
        S_DONE
    } bcr_state_t;
endpackage

// ---- bench/bcr_far_model.sv ----
// Far-side model that carries out receiver setup and display id loading
`timescale 1ns/100ps
`default_nettype none
module bcr_far_model #(
    parameter int DLY = 3
) (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    // Requests in, completions out
    input  wire logic edid_req_in,
    input  wire logic rx_req_in,
    output logic      edid_done_out,
    output logic      rx_done_out
);
    int cnt;
    // Answers each held request after DLY+1 cycles with a one-cycle done
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt <= 0;
            edid_done_out <= 1'b0;
            rx_done_out <= 1'b0;
        end else begin
            edid_done_out <= 1'b0;
            rx_done_out <= 1'b0;
            if ((edid_req_in || rx_req_in) && !edid_done_out && !rx_done_out) begin
                cnt <= (cnt == DLY) ? 0 : cnt + 1;
                edid_done_out <= (cnt == DLY) && edid_req_in;
                rx_done_out <= (cnt == DLY) && !edid_req_in;
            end else if (!edid_req_in && !rx_req_in) begin
                cnt <= 0; // A withdrawn request leaves no count behind
            end
        end
    end
endmodule // bcr_far_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the bridge configuration register
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic       mclk_in = 0, reset_n_in = 0, sa = 0, sb = 0, wr = 0, rd = 0, irq = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v;
    logic [3:0] ha = 4'hA, ia = 4'h5, aud;
    logic       ictl, rxq, edq, idone, irqn, loc, tdm, aux, rxd, edd;
    logic [1:0] seen;
    int         n_mismatch = 0, cmp_count = 0, cyc = 0;
    // Clock of 40 ns period
    always #20 mclk_in = ~mclk_in;
    bcr_bridge_config i_bcr_bridge_config (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .strap_pin_a_in(sa), .strap_pin_b_in(sb), .reg_addr_in(addr), .reg_wr_en_in(wr),
        .reg_rd_en_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata), .hdmi_irq_in(irq),
        .rx_init_done_in(rxd), .edid_load_done_in(edd), .internal_ctl_en_out(ictl),
        .rx_init_req_out(rxq), .edid_load_req_out(edq), .init_done_out(idone),
        .irq_out_n(irqn), .hdmi_audio_in(ha), .i2s_audio_in(ia), .audio_out(aud),
        .audio_src_local_out(loc), .tdm_enable_out(tdm), .aux_audio_en_out(aux));
    bcr_far_model i_bcr_far_model (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .edid_req_in(edq), .rx_req_in(rxq), .edid_done_out(edd), .rx_done_out(rxd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rst(input logic a, input logic b);
        @(negedge mclk_in);
        reset_n_in = 0;
        sa = a;
        sb = b;
        repeat (6) @(negedge mclk_in);
        reset_n_in = 1;
        @(negedge mclk_in);
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        addr = ad;
        wd = d;
        wr = 1;
        @(negedge mclk_in);
        wr = 0;
        @(negedge mclk_in);
    endtask
    task automatic rreg(input logic [7:0] ad, output logic [7:0] d);
        addr = ad;
        rd = 1;
        @(negedge mclk_in);
        rd = 0;
        d = rdata;
        @(negedge mclk_in);
    endtask
    // Watches the setup requests for a fixed span
    task automatic watch();
        seen = 2'b00;
        repeat (30) begin
            @(negedge mclk_in);
            seen |= {edq, rxq};
        end
    endtask
    task automatic t_strap();
        rst(1'b1, 1'b1);
        watch();
        chk({7'h0, ictl}, 8'h00);
        chk({6'h0, seen}, 8'h00);
        rreg(8'h54, v);
        chk(v, 8'hA1);
        $display("test strap done");
    endtask
    task automatic t_seq();
        rst(1'b0, 1'b0);
        chk({7'h0, ictl}, 8'h01);
        rreg(8'h54, v);
        chk(v, 8'h00);
        watch();
        chk({5'h0, seen, idone}, 8'h07);
        $display("test sequence done");
    endtask
    task automatic t_auto();
        rst(1'b0, 1'b0);
        wreg(8'h54, 8'h10);
        watch();
        chk({6'h0, seen[0], idone}, 8'h01);
        $display("test auto disable done");
    endtask
    task automatic t_irq();
        rst(1'b0, 1'b0);
        irq = 1;
        wreg(8'h54, 8'h4A);
        rreg(8'h54, v);
        chk(v, 8'h42);
        chk({7'h0, irqn}, 8'h00);
        rreg(8'h50, v);
        chk(v, 8'h40);
        wreg(8'h54, 8'h00);
        chk({7'h0, irqn}, 8'h01);
        rreg(8'h50, v);
        chk(v, 8'h40);
        wreg(8'h33, 8'hFF);
        rreg(8'h33, v);
        chk(v, 8'h00);
        rreg(8'h54, v);
        chk(v, 8'h00);
        irq = 0;
        $display("test interrupt done");
    endtask
    task automatic t_audio();
        wreg(8'h54, 8'h02);
        chk({4'h0, aud}, 8'h05);
        chk({5'h0, loc, tdm, aux}, 8'h04);
        wreg(8'h54, 8'h05);
        chk({4'h0, aud}, 8'h0A);
        chk({5'h0, loc, tdm, aux}, 8'h03);
        $display("test audio done");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        t_strap();
        t_seq();
        t_auto();
        t_irq();
        t_audio();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
